// file: rtl/dfc_filter.sv
// decimating fir path with offset loop and control registers
`timescale 1ns/1ps
module dfc_filter (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register write/read port
    input wire logic regWr,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [5:0] coefHiData,
    output logic [7:0] regRdData,
    // sample input stream
    input wire logic inValid,
    input wire logic [dfc_pkg::SAMPLE_W-1:0] inData,
    output logic inReady,
    // sample output stream
    output logic outValid,
    output logic [dfc_pkg::SAMPLE_W-1:0] outData,
    input wire logic outReady
);
    localparam int AW = dfc_pkg::ACC_W;
    localparam int SW = dfc_pkg::SAMPLE_W;

    logic [7:0] cfgReg_q, bandReg_q, dcReg_q;
    dfc_pkg::dfc_cfg_t cfg;

    // coefficient registers on the same write port, 14 bits per tap
    wire coefWr = regWr && regAddr >= dfc_pkg::ADDR_COEF_BASE
        && regAddr < dfc_pkg::ADDR_COEF_BASE + 8'(dfc_pkg::NTAPS);
    wire [4:0] coefWrIdx = 5'(regAddr - dfc_pkg::ADDR_COEF_BASE);

    // configuration registers; fixed-zero bits are masked
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cfgReg_q <= dfc_pkg::RST_FILT_CFG;
            bandReg_q <= dfc_pkg::RST_BAND_SEL;
            dcReg_q <= dfc_pkg::RST_DC_CTRL;
        end else if (regWr) begin
            if (regAddr == dfc_pkg::ADDR_FILT_CFG) cfgReg_q <= regWrData & dfc_pkg::MASK_FILT_CFG;
            if (regAddr == dfc_pkg::ADDR_BAND_SEL) bandReg_q <= regWrData & dfc_pkg::MASK_BAND_SEL;
            if (regAddr == dfc_pkg::ADDR_DC_CTRL) dcReg_q <= regWrData & dfc_pkg::MASK_DC_CTRL;
        end
    end

    // field decode
    assign cfg.offsEn = cfgReg_q[dfc_pkg::FLD_OFFS_EN];
    assign cfg.coefSrc = cfgReg_q[dfc_pkg::FLD_COEF_SRC];
    assign cfg.filtEn = cfgReg_q[dfc_pkg::FLD_FILT_EN];
    assign cfg.oddTap = cfgReg_q[dfc_pkg::FLD_ODD_TAP];
    assign cfg.decim = cfgReg_q[dfc_pkg::FLD_DECIM_LO +: 3];
    assign cfg.band = bandReg_q[1:0];
    assign cfg.lowLat = dcReg_q[dfc_pkg::FLD_LOW_LAT];
    assign cfg.tcCode = dcReg_q[dfc_pkg::FLD_TC_LO +: 3];

    // readback mux, registered so the port comes from a flop
    logic [7:0] rdMux;
    assign rdMux = (regAddr == dfc_pkg::ADDR_FILT_CFG) ? cfgReg_q :
                   (regAddr == dfc_pkg::ADDR_BAND_SEL) ? bandReg_q :
                   (regAddr == dfc_pkg::ADDR_DC_CTRL) ? dcReg_q : 8'h00;
    always_ff @(posedge clk) begin
        if (!rstn) regRdData <= 8'h00;
        else regRdData <= rdMux;
    end

    // time constant exponent table, 000 gives 27
    function automatic logic [4:0] tcExp(input logic [2:0] code);
        case (code)
            3'h0: tcExp = dfc_pkg::TC_EXP_000;
            3'h1: tcExp = 5'h1A;
            3'h2: tcExp = 5'h19;
            3'h3: tcExp = 5'h18;
            3'h4: tcExp = 5'h1C;
            3'h5: tcExp = 5'h1D;
            default: tcExp = dfc_pkg::TC_EXP_000;
        endcase
    endfunction

    // decimation ratio as log2; unlisted codes fall back to by two
    function automatic logic [1:0] decLog(input logic [2:0] code);
        case (code)
            dfc_pkg::DEC_BY2: decLog = 2'h1;
            dfc_pkg::DEC_BY4: decLog = 2'h2;
            dfc_pkg::DEC_NONE: decLog = 2'h0;
            dfc_pkg::DEC_BY8: decLog = 2'h3;
            default: decLog = 2'h1;
        endcase
    endfunction

    // built-in sets disabled for no-decimation and by eight
    wire useUser = cfg.coefSrc || cfg.decim == dfc_pkg::DEC_NONE || cfg.decim == dfc_pkg::DEC_BY8;
    wire [4:0] nTaps = cfg.oddTap ? 5'(dfc_pkg::NTAPS - 1) : 5'(dfc_pkg::NTAPS);

    // built-in coefficient rom: half-band low/high pass and quarter-band low pass
    function automatic logic signed [dfc_pkg::COEF_W-1:0] romCoef(input logic [2:0] decim,
        input logic [1:0] band, input logic [4:0] idx);
        logic signed [dfc_pkg::COEF_W-1:0] c;
        logic [4:0] m;
        m = (idx > 5'd11) ? 5'(5'd23 - idx) : idx;
        c = (m == 5'd11) ? 14'sh0E00 : (m == 5'd10) ? 14'sh0500 :
            (m == 5'd9) ? -14'sh0180 : (m == 5'd8) ? -14'sh0100 : 14'sh0040;
        if (decim == dfc_pkg::DEC_BY4) begin
            c = c >>> 1;
        end else if (band == dfc_pkg::BAND_HIGH && idx[0]) begin
            c = -c;
        end
        romCoef = c;
    endfunction

    // elastic input: stall input while a mac pass runs
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MAC = 3'b010,
        ST_EMIT = 3'b100
    } dfc_st_t;
    dfc_st_t state_q;

    // sample delay line
    logic signed [SW-1:0] line_q [0:dfc_pkg::NTAPS-1];
    logic [4:0] tapIdx_q;
    logic [2:0] phase_q;
    logic signed [AW-1:0] acc_q;
    logic [dfc_pkg::COEF_W-1:0] userCoef;
    logic signed [SW-1:0] corrSmp;
    logic signed [AW-1:0] dcAcc_q;

    // buffer in front of the output
    logic bufInValid, bufInReady;
    logic [SW-1:0] bufInData;

    // the store reads one cycle late, so it is addressed with the tap used next cycle
    wire [4:0] tapIdxNxt = (state_q == ST_MAC) ? 5'(tapIdx_q + 5'h1) : 5'h00;

    dfc_coef_mem uCoef (
        .clk(clk),
        .wrEn(coefWr),
        .wrAddr(coefWrIdx),
        .wrData({coefHiData, regWrData}),
        .rdAddr(tapIdxNxt),
        .rdData(userCoef)
    );

    // offset correction: leaky dc estimate with shift 2^tc
    wire [4:0] tcShift = tcExp(cfg.tcCode);
    wire signed [AW-1:0] dcEst = dcAcc_q >>> tcShift;
    assign corrSmp = cfg.offsEn ? SW'($signed(inData) - dcEst[SW-1:0]) : $signed(inData);
    wire inTake = inValid && inReady;
    always_ff @(posedge clk) begin
        if (!rstn || !cfg.offsEn) begin
            dcAcc_q <= '0;
        end else if (inTake) begin
            dcAcc_q <= dcAcc_q + AW'($signed(inData)) - dcEst;
        end
    end

    // time constant from code
    // the estimate above settles over 2^tcShift samples

    logic [SW-1:0] llPipe_q [0:dfc_pkg::LOW_LAT_CYC-1];
    logic [dfc_pkg::LOW_LAT_CYC-1:0] llVal_q;
    // one process owns the whole pipe; it freezes while the buffer is full
    always_ff @(posedge clk) begin
        if (!rstn) begin
            llVal_q <= '0;
            for (int i = 0; i < dfc_pkg::LOW_LAT_CYC; i++) llPipe_q[i] <= '0;
        end else if (bufInReady) begin
            llVal_q <= {llVal_q[dfc_pkg::LOW_LAT_CYC-2:0], inValid && cfg.lowLat};
            llPipe_q[0] <= inData;
            for (int i = 1; i < dfc_pkg::LOW_LAT_CYC; i++) llPipe_q[i] <= llPipe_q[i-1];
        end
    end

    // input ready: filter idles, or bypass/low latency flows through buffer
    assign inReady = cfg.lowLat ? bufInReady : (!cfg.filtEn ? bufInReady : state_q == ST_IDLE);

    wire [2:0] phaseLast = 3'((1 << decLog(cfg.decim)) - 1);
    wire signed [dfc_pkg::COEF_W-1:0] curCoef = useUser ? $signed(userCoef)
        : romCoef(cfg.decim, cfg.band, tapIdx_q);
    wire signed [AW-1:0] prod = AW'(curCoef * line_q[tapIdx_q]);

    // filter sequencer
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            tapIdx_q <= '0;
            phase_q <= '0;
            acc_q <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (inTake && cfg.filtEn && !cfg.lowLat) begin
                        if (phase_q == phaseLast) begin
                            phase_q <= '0;
                            state_q <= ST_MAC;
                            tapIdx_q <= '0;
                            acc_q <= '0;
                        end else begin
                            phase_q <= 3'(phase_q + 3'h1);
                        end
                    end
                end
                ST_MAC: begin
                    acc_q <= acc_q + prod;
                    if (tapIdx_q == 5'(nTaps - 5'h1)) state_q <= ST_EMIT;
                    else tapIdx_q <= 5'(tapIdx_q + 5'h1);
                end
                ST_EMIT: begin
                    if (bufInReady) state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // delay line shifts on each accepted filtered sample
    always_ff @(posedge clk) begin
        if (inTake && cfg.filtEn && !cfg.lowLat) begin
            line_q[0] <= corrSmp;
            for (int i = 1; i < dfc_pkg::NTAPS; i++) line_q[i] <= line_q[i-1];
        end
    end

    // source select into the output buffer
    assign bufInValid = cfg.lowLat ? llVal_q[dfc_pkg::LOW_LAT_CYC-1] :
        (!cfg.filtEn ? inValid : state_q == ST_EMIT);
    assign bufInData = cfg.lowLat ? llPipe_q[dfc_pkg::LOW_LAT_CYC-1] :
        (!cfg.filtEn ? corrSmp : acc_q[SW+12:13]);

    // two-entry skid buffer; outputs straight from flops
    logic [SW-1:0] skid_q;
    logic skidV_q;
    assign bufInReady = !skidV_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            outValid <= 1'b0;
            outData <= '0;
            skidV_q <= 1'b0;
            skid_q <= '0;
        end else begin
            if (!outValid || outReady) begin
                outValid <= skidV_q || bufInValid;
                outData <= skidV_q ? skid_q : bufInData;
                if (skidV_q) skidV_q <= 1'b0;
            end else if (bufInValid && bufInReady) begin
                skidV_q <= 1'b1;
                skid_q <= bufInData;
            end
        end
    end
endmodule

// file: rtl/dfc_pkg.sv
// shared constants and types for the decimating filter path
package dfc_pkg;
    localparam int SAMPLE_W = 14;
    localparam int ACC_W = 32;
    localparam int NTAPS = 24;
    localparam int COEF_W = 14;
    // register addresses on the serial control port
    localparam logic [7:0] ADDR_DC_CTRL = 8'h1A;
    localparam logic [7:0] ADDR_FILT_CFG = 8'h1B;
    localparam logic [7:0] ADDR_BAND_SEL = 8'h1D;
    localparam logic [7:0] ADDR_COEF_BASE = 8'h20;
    // field positions in filter_decim_config
    localparam int FLD_OFFS_EN = 7;
    localparam int FLD_COEF_SRC = 5;
    localparam int FLD_FILT_EN = 4;
    localparam int FLD_ODD_TAP = 3;
    localparam int FLD_DECIM_LO = 0;
    // field positions in dc control register
    localparam int FLD_LOW_LAT = 7;
    localparam int FLD_TC_LO = 4;
    // reset values
    localparam logic [7:0] RST_FILT_CFG = 8'h00;
    localparam logic [7:0] RST_BAND_SEL = 8'h00;
    localparam logic [7:0] RST_DC_CTRL = 8'h00;
    // writable masks: fixed-zero bits stay zero
    localparam logic [7:0] MASK_FILT_CFG = 8'hBF;
    localparam logic [7:0] MASK_BAND_SEL = 8'h03;
    localparam logic [7:0] MASK_DC_CTRL = 8'hF0;
    // decimation codes
    localparam logic [2:0] DEC_BY2 = 3'h0;
    localparam logic [2:0] DEC_BY4 = 3'h1;
    localparam logic [2:0] DEC_NONE = 3'h3;
    localparam logic [2:0] DEC_BY8 = 3'h4;
    // band codes
    localparam logic [1:0] BAND_LOW = 2'h0;
    localparam logic [1:0] BAND_HIGH = 2'h1;
    // low latency path depth in clocks
    localparam int LOW_LAT_CYC = 10;
    // offset loop time-constant exponent per code (000 gives 27)
    localparam logic [4:0] TC_EXP_000 = 5'h1B;

    typedef struct packed {
        logic offsEn;
        logic coefSrc;
        logic filtEn;
        logic oddTap;
        logic [2:0] decim;
        logic [1:0] band;
        logic lowLat;
        logic [2:0] tcCode;
    } dfc_cfg_t;

    typedef struct packed {
        logic valid;
        logic [SAMPLE_W-1:0] data;
    } dfc_smp_t;
endpackage

// file: rtl/dfc_coef_mem.sv
// user coefficient store, registered read
`timescale 1ns/1ps
module dfc_coef_mem (
    // clock
    input wire logic clk,
    // write side
    input wire logic wrEn,
    input wire logic [4:0] wrAddr,
    input wire logic [dfc_pkg::COEF_W-1:0] wrData,
    // read side
    input wire logic [4:0] rdAddr,
    output logic [dfc_pkg::COEF_W-1:0] rdData
);
    logic [dfc_pkg::COEF_W-1:0] mem [0:dfc_pkg::NTAPS-1];

    // write port and registered read
    always_ff @(posedge clk) begin
        if (wrEn && wrAddr < 5'(dfc_pkg::NTAPS)) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= (rdAddr < 5'(dfc_pkg::NTAPS)) ? mem[rdAddr] : '0;
    end
endmodule

// file: verif/dfc_filter_chk.sv
// port checker for the decimating filter path
`timescale 1ns/1ps
module dfc_filter_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic regWr,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [5:0] coefHiData,
    input wire logic [7:0] regRdData,
    // sample streams
    input wire logic inValid,
    input wire logic [dfc_pkg::SAMPLE_W-1:0] inData,
    input wire logic inReady,
    input wire logic outValid,
    input wire logic [dfc_pkg::SAMPLE_W-1:0] outData,
    input wire logic outReady
);
    logic [7:0] filtQ, bandQ, dcQ;
    logic take;
    logic mapped;
    assign take = inValid && inReady;
    assign mapped = regAddr inside {dfc_pkg::ADDR_FILT_CFG, dfc_pkg::ADDR_BAND_SEL, dfc_pkg::ADDR_DC_CTRL};
    // shadow of the writable bits, so readback is judged without seeing the design
    always_ff @(posedge clk) begin
        if (!rstn) begin
            filtQ <= 8'h00;
            bandQ <= 8'h00;
            dcQ <= 8'h00;
        end else if (regWr) begin
            if (regAddr == dfc_pkg::ADDR_FILT_CFG) filtQ <= regWrData & dfc_pkg::MASK_FILT_CFG;
            if (regAddr == dfc_pkg::ADDR_BAND_SEL) bandQ <= regWrData & dfc_pkg::MASK_BAND_SEL;
            if (regAddr == dfc_pkg::ADDR_DC_CTRL) dcQ <= regWrData & dfc_pkg::MASK_DC_CTRL;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // filter config readback, bit six fixed
    a_filt_readback: assert property (
        $past(rstn) && !$past(regWr) && $past(regAddr) == dfc_pkg::ADDR_FILT_CFG |-> regRdData == filtQ)
        else $error("filter config readback wrong");
    a_band_readback: assert property (
        $past(rstn) && !$past(regWr) && $past(regAddr) == dfc_pkg::ADDR_BAND_SEL |-> regRdData == bandQ)
        else $error("band select readback wrong");
    a_dc_readback: assert property (
        $past(rstn) && !$past(regWr) && $past(regAddr) == dfc_pkg::ADDR_DC_CTRL |-> regRdData == dcQ)
        else $error("loop control readback wrong");
    a_unmapped_zero: assert property (
        $past(rstn) && !$past(mapped) |-> regRdData == 8'h00) else $error("unmapped read not zero");
    // bypass passes the sample one cycle on
    a_bypass_pass: assert property (
        take && !filtQ[dfc_pkg::FLD_FILT_EN] && !dcQ[dfc_pkg::FLD_LOW_LAT] && !outValid
        |=> outValid && outData == $past(inData)) else $error("bypass sample lost or late");
    // low latency output after ten plus one cycles
    a_lowlat_delay: assert property (
        take && dcQ[dfc_pkg::FLD_LOW_LAT] && !outValid |-> ##11 outValid) else $error("low latency word late");
    a_out_hold: assert property (
        outValid && !outReady |=> outValid && $stable(outData)) else $error("stalled word changed");
    a_reset_clear: assert property (
        rstn && !$past(rstn) |-> !outValid && regRdData == 8'h00) else $error("state not clear after reset");
endmodule
bind dfc_filter dfc_filter_chk chk (.clk(clk), .rstn(rstn), .regWr(regWr), .regAddr(regAddr),
    .regWrData(regWrData), .coefHiData(coefHiData), .regRdData(regRdData), .inValid(inValid),
    .inData(inData), .inReady(inReady), .outValid(outValid), .outData(outData), .outReady(outReady));

// file: verif/dfc_sink.sv
// capturing receiver on the sample output stream
`timescale 1ns/1ps
module dfc_sink (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // stall mode: 0 never, 1 random, 2 always
    input wire logic [1:0] stall,
    // sample stream
    input wire logic outValid,
    input wire logic [dfc_pkg::SAMPLE_W-1:0] outData,
    output logic outReady
);
    logic [dfc_pkg::SAMPLE_W-1:0] got [$];
    initial outReady = 1'b0;
    // ready moves on the falling edge, clear of the sampling edge
    always @(negedge clk) begin
        outReady <= (stall == 2'd0) || (stall == 2'd1 && $urandom % 3 != 0);
    end
    // keep every accepted word
    always @(posedge clk) begin
        if (rstn && outValid && outReady) begin
            got.push_back(outData);
        end
    end
endmodule

// file: verif/testbench.sv
// self-checking bench for the decimating filter path
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin numErrors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench;
    logic clk, rstn, regWr, inValid, inReady, outValid, outReady;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [5:0] coefHiData;
    logic [13:0] inData, outData, x;
    logic [1:0] stall;
    logic [13:0] sent [$];
    logic [7:0] regA [3] = '{dfc_pkg::ADDR_FILT_CFG, dfc_pkg::ADDR_BAND_SEL, dfc_pkg::ADDR_DC_CTRL};
    logic [8:0] modeT [8] = '{9'h030, 9'h038, 9'h031, 9'h013, 9'h014, 9'h010, 9'h110, 9'h011};
    int numErrors = 0;
    int nTests = 0;
    int n;
    dfc_filter dut (.clk(clk), .rstn(rstn), .regWr(regWr), .regAddr(regAddr), .regWrData(regWrData),
        .coefHiData(coefHiData), .regRdData(regRdData), .inValid(inValid), .inData(inData),
        .inReady(inReady), .outValid(outValid), .outData(outData), .outReady(outReady));
    dfc_sink sink (.clk(clk), .rstn(rstn), .stall(stall), .outValid(outValid), .outData(outData),
        .outReady(outReady));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // decimation ratio per code; unlisted codes act as two
    function automatic int ratioOf(input logic [2:0] d);
        case (d)
            dfc_pkg::DEC_BY4: return 4;
            dfc_pkg::DEC_NONE: return 1;
            dfc_pkg::DEC_BY8: return 8;
            default: return 2;
        endcase
    endfunction
    // level is predictable only with the user taps (first and last set to half gain)
    function automatic bit userTaps(input logic [7:0] c);
        return c[dfc_pkg::FLD_COEF_SRC] || c[2:0] == dfc_pkg::DEC_NONE || c[2:0] == dfc_pkg::DEC_BY8;
    endfunction
    // odd length drops the last tap, halving the steady level
    function automatic logic [13:0] expOut(input logic odd, input logic [13:0] v);
        return odd ? v >> 1 : v;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [5:0] h);
        @(negedge clk);
        regWr = 1'b1;
        regAddr = a;
        regWrData = d;
        coefHiData = h;
        @(negedge clk);
        regWr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        regAddr = a;
        @(negedge clk);
        `CHK("regRdData", e, regRdData)
    endtask
    task automatic send(input int cnt, input logic [13:0] v, input bit rnd);
        for (int i = 0; i < cnt; i++) begin
            @(negedge clk);
            inValid = 1'b1;
            inData = rnd ? 14'($urandom) : v;
            // ready only moves on the rising edge, so the falling edge sees what the next rise will take
            while (inReady !== 1'b1) @(negedge clk);
            sent.push_back(inData);
        end
        @(negedge clk);
        inValid = 1'b0;
    endtask
    // bounded wait for the expected words, then a margin to catch extras
    task automatic drain(input int cnt);
        for (int i = 0; i < 2000 && sink.got.size() < cnt; i++) @(negedge clk);
        repeat (40) @(negedge clk);
    endtask
    task automatic endSim();
        $display("comparisons %0d mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #(60000 * 5);
        numErrors++;
        endSim();
    end
    initial begin
        {rstn, regWr, inValid, regAddr, regWrData, coefHiData, inData, stall} = '0;
        void'($urandom(69938));
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        // reset values, then fixed-zero bits stay zero
        for (int i = 0; i < 3; i++) begin
            rd(regA[i], 8'h00);
            wr(regA[i], 8'hFF, 6'h00);
            rd(regA[i], 8'hFF & (i == 0 ? dfc_pkg::MASK_FILT_CFG : i == 1 ? dfc_pkg::MASK_BAND_SEL :
                dfc_pkg::MASK_DC_CTRL));
            wr(regA[i], 8'h00, 6'h00);
        end
        rd(8'h55, 8'h00);
        // bypass (filling the buffer first) and low latency pass samples unchanged
        for (int i = 0; i < 2; i++) begin
            wr(dfc_pkg::ADDR_DC_CTRL, i == 0 ? 8'h00 : 8'h80, 6'h00);
            wr(dfc_pkg::ADDR_FILT_CFG, i == 0 ? 8'h00 : 8'h10, 6'h00);
            sent.delete();
            sink.got.delete();
            stall = i == 0 ? 2'd2 : 2'd1;
            fork
                send(40, 14'h0000, 1'b1);
                begin
                    repeat (30) @(negedge clk);
                    if (i == 0) `CHK("inReady when full", 1'b0, inReady)
                    stall = 2'd1;
                end
            join
            drain(40);
            `CHK("passed count", 40, sink.got.size())
            foreach (sent[k]) `CHK("passed sample", sent[k], sink.got[k])
        end
        wr(dfc_pkg::ADDR_DC_CTRL, 8'h00, 6'h00);
        // user taps written before they are selected
        for (int i = 0; i < dfc_pkg::NTAPS; i++) begin
            wr(dfc_pkg::ADDR_COEF_BASE + 8'(i), 8'h00, (i == 0 || i == 23) ? 6'h10 : 6'h00);
        end
        // every decimation code and band, constant level in
        foreach (modeT[m]) begin
            x = {1'b0, 12'($urandom), 1'b0};
            wr(dfc_pkg::ADDR_BAND_SEL, {7'h00, modeT[m][8]}, 6'h00);
            wr(dfc_pkg::ADDR_FILT_CFG, modeT[m][7:0], 6'h00);
            sent.delete();
            sink.got.delete();
            send(96, x, 1'b0);
            n = 96 / ratioOf(modeT[m][2:0]);
            drain(n);
            `CHK("filtered count", n, sink.got.size())
            if (userTaps(modeT[m][7:0])) `CHK("filtered level", expOut(modeT[m][3], x), sink.got[$])
        end
        endSim();
    end
endmodule
